// ### receiver_interrupt_control_tb.sv
// Self-checking testbench for the receiver interrupt control block
`timescale 1ns/1ps
`include "rxic_defs.vh"
`define CK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
	$display("unexpected at %0t: %h vs %h", $time, g, e); end end
module receiver_interrupt_control_tb;
	logic        hclk, hresetn, hsel, hwrite, forced_lock, rx_sample_valid, clk_en;
	logic [31:0] haddr, hwdata, d;
	logic [1:0]  htrans, ramp_zero_cross_in;
	logic [7:0]  serial_audio_input_pin, evt;
	logic [23:0] rx_sample_in;
	wire  [31:0] hrdata;
	wire         hreadyout, hresp, passthru_out_pin, rx_input_bit, port_phase_align;
	wire         irq_out, irq_oe, irq_pending, irq_line;
	wire  [23:0] rx_sample_out;
	wire  [5:0]  adc_right_gain;
	wire  [1:0]  ramp_zero_cross_sel, deemph_filter_sel, lock_mode_sel;
	wire  [2:0]  status_buf_mode;
	int          miscompares, checks, n;
	int          bt[6] = '{7, 5, 4, 3, 1, 0};
	logic [7:0]  gi[4] = '{8'h10, 8'h30, 8'h0f, 8'h3b};
	logic [5:0]  go[4] = '{6'h0f, 6'h31, 6'h0f, 6'h3b};
	logic [23:0] ex[3] = '{24'h5a5a5a, 24'h0, 24'h123456};
	localparam [31:0] A_GN = `RXIC_IDX_RIGHT_LEVEL * 4, A_MD = `RXIC_IDX_MODE_CTRL * 4,
		A_SL = `RXIC_IDX_INPUT_SEL * 4, A_FL = `RXIC_IDX_EVENT_FLAGS * 4,
		A_MK = `RXIC_IDX_ENABLE_MASK * 4, A_TH = `RXIC_IDX_TRIG_HIGH * 4,
		A_TL = `RXIC_IDX_TRIG_LOW * 4, A_BF = `RXIC_IDX_BUF_CTRL * 4,
		A_FM = `RXIC_IDX_FAULT_MASK * 4;
	rxic_top dut (.*, .hsize(3'h2), .hready(hreadyout),
		.pll_unlock_in(evt[7]), .qsub_block_in(evt[5]), .cstat_buffer_in(evt[4]),
		.userdata_buffer_in(evt[3]), .adc_overrange_in(evt[1]),
		.rx_fault_in({evt[6], 5'h0, evt[0]}));
	rxic_host_pin host (.*);
	// ----------------------------------------
	// Clock, watchdog and bus tasks
	// ----------------------------------------
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	initial begin
		#100000;
		miscompares++;
		report_and_stop;
	end
	task report_and_stop;
		if (miscompares == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task w(input int k);
		repeat (k) @(posedge hclk);
	endtask
	task xf(input logic wr, input [31:0] a, input [7:0] v);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= {24'h0, v};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		d = hrdata;
	endtask
	task rc(input [31:0] a, input [31:0] e);
		xf(1'b0, a, 8'h0);
		`CK(d, e)
	endtask
	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		{hresetn, hsel, hwrite, forced_lock, evt, serial_audio_input_pin} = '0;
		{haddr, hwdata, htrans, rx_sample_in} = '0;
		ramp_zero_cross_in = 2'h2;
		clk_en = 1'b1;
		rx_sample_valid = 1'b1;
		miscompares = 0;
		checks = 0;
		w(4);
		hresetn <= 1'b1;
		w(1);
		rc(A_FL, 0);
		rc(A_MK, `RXIC_RST_ENABLE_MASK);
		rc(A_TL, `RXIC_RST_TRIG);
		rc(A_BF, 8'h40);
		rc(32'h94, 0);
		`CK(ramp_zero_cross_sel, 2'h2)
		xf(1'b1, A_BF, 8'h87);
		xf(1'b1, A_MD, 8'h80);
		w(1);
		`CK({lock_mode_sel, port_phase_align, status_buf_mode}, 6'h2f)
		for (n = 0; n < 4; n++) begin
			xf(1'b1, A_GN, gi[n]);
			w(2);
			`CK(adc_right_gain, go[n])
		end
		for (n = 0; n < 8; n++) begin
			serial_audio_input_pin <= 8'h1 << n;
			xf(1'b1, A_SL, {1'b0, n[2:0], 1'b0, 3'(7 - n)});
			w(5);
			`CK({passthru_out_pin, rx_input_bit}, 2'h2)
			xf(1'b1, A_SL, {1'b0, 3'(7 - n), 1'b0, n[2:0]});
			w(5);
			`CK({passthru_out_pin, rx_input_bit}, 2'h1)
		end
		clk_en <= 1'b0;
		serial_audio_input_pin <= 8'h01;
		w(6);
		`CK({passthru_out_pin, rx_input_bit}, 2'h1)
		clk_en <= 1'b1;
		w(6);
		`CK({passthru_out_pin, rx_input_bit}, 2'h2)
		forced_lock <= 1'b1;
		for (n = 1; n < 4; n++) begin
			xf(1'b1, A_MD, {2'h0, n[1:0], 4'h0});
			w(2);
			`CK(deemph_filter_sel, n[1:0])
		end
		forced_lock <= 1'b0;
		w(2);
		`CK(deemph_filter_sel, 2'h0)
		xf(1'b1, A_FM, 8'h01);
		foreach (bt[k]) begin
			xf(1'b1, A_MK, 8'h1 << bt[k]);
			evt[bt[k]] <= 1'b1;
			w(2);
			evt <= 8'h0;
			w(6);
			`CK(irq_pending, 1'b1)
			rc(A_FL, 8'h1 << bt[k]);
			w(2);
			`CK(irq_pending, 1'b0)
			rc(A_FL, 0);
		end
		evt <= 8'hc0;
		w(2);
		evt <= 8'h0;
		w(6);
		rc(A_FL, 0);
		xf(1'b1, A_MK, 8'h30);
		xf(1'b1, A_TH, 8'h10);
		xf(1'b1, A_TL, 8'h20);
		evt <= 8'h20;
		w(8);
		rc(A_FL, 0);
		evt <= 8'h10;
		w(8);
		rc(A_FL, 8'h30);
		w(2);
		rc(A_FL, 8'h10);
		for (n = 0; n < 3; n++) begin
			xf(1'b1, A_MD, {4'h0, n[1:0], 2'h0});
			w(3);
			`CK(irq_line, n == 0)
		end
		evt <= 8'h0;
		w(6);
		rc(A_FL, 8'h10);
		w(3);
		`CK({irq_oe, irq_line}, 2'h1)
		for (n = 0; n < 3; n++) begin
			xf(1'b1, A_MD, n[7:0]);
			evt <= 8'h0;
			rx_sample_in <= 24'h5a5a5a;
			w(4);
			evt <= 8'h01;
			w(6);
			rx_sample_in <= 24'h123456;
			w(4);
			`CK(rx_sample_out, ex[n])
		end
		evt <= 8'h0;
		xf(1'b1, A_FM, 8'h41);
		xf(1'b1, A_MK, 8'h01);
		xf(1'b1, A_MD, 8'h01);
		evt <= 8'h40;
		rx_sample_in <= 24'h654321;
		w(6);
		`CK(rx_sample_out, 24'h654321)
		rc(A_FL, 8'h01);
		hresetn <= 1'b0;
		w(2);
		hresetn <= 1'b1;
		w(1);
		rc(A_MK, 0);
		rc(A_BF, 8'h40);
		`CK({irq_oe, irq_line}, 2'h2)
		report_and_stop;
	end
endmodule // receiver_interrupt_control_tb

// ### rxic_defs.vh
// Register offsets, field positions and reset values for the receiver interrupt control block
`ifndef RXIC_DEFS_VH
`define RXIC_DEFS_VH

// ----------------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------------
`define RXIC_IDX_RIGHT_LEVEL   8'h1d
`define RXIC_IDX_MODE_CTRL     8'h1e
`define RXIC_IDX_INPUT_SEL     8'h1f
`define RXIC_IDX_EVENT_FLAGS   8'h20
`define RXIC_IDX_ENABLE_MASK   8'h21
`define RXIC_IDX_TRIG_HIGH     8'h22
`define RXIC_IDX_TRIG_LOW      8'h23
`define RXIC_IDX_BUF_CTRL      8'h24
`define RXIC_IDX_FAULT_MASK    8'h27

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RXIC_RST_RIGHT_LEVEL   6'h00
`define RXIC_RST_MODE_CTRL     8'h00
`define RXIC_RST_INPUT_SEL     8'h00
`define RXIC_RST_ENABLE_MASK   8'h00
`define RXIC_RST_TRIG          8'h00
`define RXIC_RST_BUF_CTRL      8'h40
`define RXIC_RST_FAULT_MASK    7'h00

// ----------------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------------
`define RXIC_MODE_ALIGN_BIT    7
`define RXIC_MODE_DEEMPH_HI    5
`define RXIC_MODE_DEEMPH_LO    4
`define RXIC_MODE_PIN_HI       3
`define RXIC_MODE_PIN_LO       2
`define RXIC_MODE_HOLD_HI      1
`define RXIC_MODE_HOLD_LO      0
`define RXIC_MODE_WMASK        8'hbf
`define RXIC_SEL_WMASK         8'h77
`define RXIC_FLAG_WMASK        8'hbb
`define RXIC_BUF_WMASK         8'hc7
`define RXIC_PIN_ACT_HIGH      2'h0
`define RXIC_PIN_ACT_LOW       2'h1
`define RXIC_PIN_OPEN_DRAIN    2'h2
`define RXIC_HOLD_LAST         2'h0
`define RXIC_HOLD_ZERO         2'h1
`define RXIC_HOLD_PASS         2'h2
`define RXIC_TRIG_RISE         2'h0
`define RXIC_TRIG_FALL         2'h1
`define RXIC_TRIG_LEVEL        2'h2
`define RXIC_FAULT_AUDIO_MASK  7'h1f
`define RXIC_GAIN_MAX          6'h0f
`define RXIC_GAIN_MIN          6'h31

`endif

// ### rxic_host_pin.sv
// Host-side model of the interrupt pin with its board pull-up
`timescale 1ns/1ps
module rxic_host_pin (
	input  wire logic irq_out,
	input  wire logic irq_oe,
	output wire logic irq_line
);
	// Released pin rises to the pull-up level
	assign irq_line = irq_oe ? irq_out : 1'b1;
endmodule // rxic_host_pin

// ### rxic_top.v
// Receiver control registers, input multiplexers and interrupt logic on AHB-Lite
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ps
`include "rxic_defs.vh"

module rxic_top (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        clk_en,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output wire        hreadyout,
	output wire        hresp,
	input  wire [7:0]  serial_audio_input_pin,
	output reg         passthru_out_pin,
	output reg         rx_input_bit,
	input  wire        pll_unlock_in,
	input  wire        qsub_block_in,
	input  wire        cstat_buffer_in,
	input  wire        userdata_buffer_in,
	input  wire        adc_overrange_in,
	input  wire [6:0]  rx_fault_in,
	input  wire [23:0] rx_sample_in,
	input  wire        rx_sample_valid,
	output reg  [23:0] rx_sample_out,
	input  wire        forced_lock,
	output reg  [5:0]  adc_right_gain,
	output wire [1:0]  ramp_zero_cross_sel,
	input  wire [1:0]  ramp_zero_cross_in,
	output wire        port_phase_align,
	output reg  [1:0]  deemph_filter_sel,
	output wire [1:0]  lock_mode_sel,
	output wire [2:0]  status_buf_mode,
	output wire        irq_out,
	output wire        irq_oe,
	output wire        irq_pending
);

	// ------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------
	function is_idx;
		input [31:0] a;
		input [7:0]  idx;
		begin
			is_idx = (a[31:2] == {22'h000000, idx}) && (a[1:0] == 2'h0);
		end
	endfunction

	function [5:0] clamp_gain;
		input [5:0] g;
		begin
			if (!g[5] && g > `RXIC_GAIN_MAX)
				clamp_gain = `RXIC_GAIN_MAX;
			else if (g[5] && g < `RXIC_GAIN_MIN)
				clamp_gain = `RXIC_GAIN_MIN;
			else
				clamp_gain = g;
		end
	endfunction

	function trig_fire;
		input hi;
		input lo;
		input cur;
		input prev;
		begin
			case ({hi, lo})
				`RXIC_TRIG_RISE:  trig_fire = cur & ~prev;
				`RXIC_TRIG_FALL:  trig_fire = ~cur & prev;
				`RXIC_TRIG_LEVEL: trig_fire = cur;
				default:          trig_fire = 1'b0;
			endcase
		end
	endfunction

	// ------------------------------------------------------------------
	// Synchronisers for pin and source inputs
	// ------------------------------------------------------------------
	reg  [19:0] sync1_r;
	reg  [19:0] sync2_r;
	wire [19:0] async_in = {pll_unlock_in, qsub_block_in, cstat_buffer_in, userdata_buffer_in,
	                        adc_overrange_in, rx_fault_in, serial_audio_input_pin};

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_r <= 20'h00000;
			sync2_r <= 20'h00000;
		end else if (clk_en) begin
			sync1_r <= async_in;
			sync2_r <= sync1_r;
		end
	end

	// Only the second stage is read by logic
	wire [7:0] rxp_s    = sync2_r[7:0];
	wire [6:0] fault_s  = sync2_r[14:8];
	wire       ovr_s    = sync2_r[15];
	wire       udat_s   = sync2_r[16];
	wire       cstat_s  = sync2_r[17];
	wire       qsub_s   = sync2_r[18];
	wire       unlock_s = sync2_r[19];

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	reg  [5:0]  right_level_r;
	reg  [7:0]  mode_ctrl_r;
	reg  [7:0]  input_sel_r;
	reg  [7:0]  enable_mask_r;
	reg  [7:0]  trig_high_r;
	reg  [7:0]  trig_low_r;
	reg  [7:0]  buf_ctrl_r;
	reg  [6:0]  fault_mask_r;
	reg  [7:0]  flags_r;
	reg  [7:0]  cond_d_r;
	reg         wr_pend_r;
	reg  [7:0]  wr_idx_r;

	wire        a_valid = hsel && hready && htrans[1];
	wire        a_write = a_valid && hwrite;
	wire        a_read  = a_valid && !hwrite;
	wire [7:0]  wdat    = hwdata[7:0];

	// Zero wait states: every transfer completes in one data phase
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_idx_r  <= 8'h00;
		end else if (clk_en) begin
			wr_pend_r <= a_write;
			wr_idx_r  <= haddr[9:2];
			// Writes outside the register window are dropped
			if (a_write && (haddr[31:10] != 22'h000000 || haddr[1:0] != 2'h0))
				wr_pend_r <= 1'b0;
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			right_level_r <= `RXIC_RST_RIGHT_LEVEL;
			mode_ctrl_r   <= `RXIC_RST_MODE_CTRL;
			input_sel_r   <= `RXIC_RST_INPUT_SEL;
			enable_mask_r <= `RXIC_RST_ENABLE_MASK;
			trig_high_r   <= `RXIC_RST_TRIG;
			trig_low_r    <= `RXIC_RST_TRIG;
			buf_ctrl_r    <= `RXIC_RST_BUF_CTRL;
			fault_mask_r  <= `RXIC_RST_FAULT_MASK;
		end else if (clk_en && wr_pend_r) begin
			case (wr_idx_r)
				`RXIC_IDX_RIGHT_LEVEL: right_level_r <= wdat[5:0];
				`RXIC_IDX_MODE_CTRL:   mode_ctrl_r   <= wdat & `RXIC_MODE_WMASK;
				`RXIC_IDX_INPUT_SEL:   input_sel_r   <= wdat & `RXIC_SEL_WMASK;
				`RXIC_IDX_ENABLE_MASK: enable_mask_r <= wdat & `RXIC_FLAG_WMASK;
				`RXIC_IDX_TRIG_HIGH:   trig_high_r   <= wdat & `RXIC_FLAG_WMASK;
				`RXIC_IDX_TRIG_LOW:    trig_low_r    <= wdat & `RXIC_FLAG_WMASK;
				`RXIC_IDX_BUF_CTRL:    buf_ctrl_r    <= wdat & `RXIC_BUF_WMASK;
				`RXIC_IDX_FAULT_MASK:  fault_mask_r  <= wdat[6:0];
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Control outputs
	// ------------------------------------------------------------------
	assign port_phase_align    = mode_ctrl_r[`RXIC_MODE_ALIGN_BIT];
	assign lock_mode_sel       = buf_ctrl_r[7:6];
	assign status_buf_mode     = buf_ctrl_r[2:0];
	assign ramp_zero_cross_sel = ramp_zero_cross_in;

	wire [1:0] deemph_code = mode_ctrl_r[`RXIC_MODE_DEEMPH_HI:`RXIC_MODE_DEEMPH_LO];
	wire [1:0] pin_fmt     = mode_ctrl_r[`RXIC_MODE_PIN_HI:`RXIC_MODE_PIN_LO];
	wire [1:0] hold_mode   = mode_ctrl_r[`RXIC_MODE_HOLD_HI:`RXIC_MODE_HOLD_LO];

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			adc_right_gain    <= 6'h00;
			deemph_filter_sel <= 2'h0;
			passthru_out_pin  <= 1'b0;
			rx_input_bit      <= 1'b0;
		end else if (clk_en) begin
			// Register keeps the raw code; only the output is limited
			adc_right_gain    <= clamp_gain(right_level_r);
			deemph_filter_sel <= forced_lock ? deemph_code : 2'h0;
			passthru_out_pin  <= rxp_s[input_sel_r[6:4]];
			rx_input_bit      <= rxp_s[input_sel_r[2:0]];
		end
	end

	// ------------------------------------------------------------------
	// Receiver error sample policy
	// ------------------------------------------------------------------
	wire audio_fault = |(fault_s & fault_mask_r & `RXIC_FAULT_AUDIO_MASK);
	wire any_fault   = |(fault_s & fault_mask_r);
	reg  [23:0] last_good_r;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_sample_out <= 24'h000000;
			last_good_r   <= 24'h000000;
		end else if (clk_en && rx_sample_valid) begin
			if (!audio_fault) begin
				rx_sample_out <= rx_sample_in;
				last_good_r   <= rx_sample_in;
			end else begin
				case (hold_mode)
					`RXIC_HOLD_LAST: rx_sample_out <= last_good_r;
					`RXIC_HOLD_ZERO: rx_sample_out <= 24'h000000;
					`RXIC_HOLD_PASS: rx_sample_out <= rx_sample_in;
					// Reserved code behaves as hold
					default:         rx_sample_out <= last_good_r;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// Interrupt event detection and sticky flags
	// ------------------------------------------------------------------
	wire [7:0] cond = {unlock_s, 1'b0, qsub_s, cstat_s, udat_s,
	                   1'b0, ovr_s, any_fault};
	wire [7:0] fire;
	// Status read clears at its address phase, so a set in that same cycle survives
	wire       rd_clr = a_read && is_idx(haddr, `RXIC_IDX_EVENT_FLAGS);

	// ------------------------------------------------------------------
	// Per-source trigger decode
	// ------------------------------------------------------------------
	genvar src;
	generate
		for (src = 0; src < 8; src = src + 1) begin : g_trig
			assign fire[src] = trig_fire(trig_high_r[src], trig_low_r[src], cond[src],
			                             cond_d_r[src]);
		end
	endgenerate

	wire [7:0] flags_masked = flags_r & enable_mask_r;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cond_d_r <= 8'h00;
			flags_r  <= 8'h00;
		end else if (clk_en) begin
			cond_d_r <= cond;
			// Set wins over read clear; masked sources never reach the status bits
			flags_r  <= ((rd_clr ? 8'h00 : flags_r) | (fire & enable_mask_r))
			            & `RXIC_FLAG_WMASK;
		end
	end

	// ------------------------------------------------------------------
	// Interrupt pin
	// ------------------------------------------------------------------
	// Format alone sets polarity; trigger modes only decide when flags set
	assign irq_pending = |flags_masked;
	assign irq_out = (pin_fmt == `RXIC_PIN_ACT_HIGH) ? irq_pending :
	                 (pin_fmt == `RXIC_PIN_ACT_LOW)  ? ~irq_pending : 1'b0;
	// Reserved format leaves the pin released
	assign irq_oe  = (pin_fmt == `RXIC_PIN_OPEN_DRAIN) ? irq_pending :
	                 (pin_fmt == `RXIC_PIN_ACT_HIGH || pin_fmt == `RXIC_PIN_ACT_LOW);

	// ------------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------------
	// Read data is captured at the address phase and stands for the data phase
	reg [7:0] rd_nxt;

	always @* begin
		rd_nxt = 8'h00;
		if (is_idx(haddr, `RXIC_IDX_RIGHT_LEVEL)) rd_nxt = {2'h0, right_level_r};
		if (is_idx(haddr, `RXIC_IDX_MODE_CTRL))   rd_nxt = mode_ctrl_r;
		if (is_idx(haddr, `RXIC_IDX_INPUT_SEL))   rd_nxt = input_sel_r;
		if (is_idx(haddr, `RXIC_IDX_EVENT_FLAGS)) rd_nxt = flags_masked;
		if (is_idx(haddr, `RXIC_IDX_ENABLE_MASK)) rd_nxt = enable_mask_r;
		if (is_idx(haddr, `RXIC_IDX_TRIG_HIGH))   rd_nxt = trig_high_r;
		if (is_idx(haddr, `RXIC_IDX_TRIG_LOW))    rd_nxt = trig_low_r;
		if (is_idx(haddr, `RXIC_IDX_BUF_CTRL))    rd_nxt = buf_ctrl_r;
		if (is_idx(haddr, `RXIC_IDX_FAULT_MASK))  rd_nxt = {1'b0, fault_mask_r};
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= 32'h00000000;
		else if (clk_en && a_read)
			hrdata <= {24'h000000, rd_nxt};
	end

endmodule // rxic_top

// ### rxic_top_monitor.sv
// Port-level assertions for the receiver interrupt control block
`timescale 1ns/1ps
module rxic_top_monitor (
	input wire        hclk,
	input wire        hresetn,
	input wire        clk_en,
	input wire        hsel,
	input wire [31:0] haddr,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire        hready,
	input wire [31:0] hrdata,
	input wire        hreadyout,
	input wire        hresp,
	input wire        forced_lock,
	input wire [5:0]  adc_right_gain,
	input wire [1:0]  ramp_zero_cross_sel,
	input wire [1:0]  ramp_zero_cross_in,
	input wire [1:0]  deemph_filter_sel,
	input wire        irq_out,
	input wire        irq_oe,
	input wire        irq_pending
);
	// ----------------------------------------
	// Data phases of status reads and mask writes
	// ----------------------------------------
	wire  acc = hsel && hready && htrans[1];
	logic rd_q, wr_q;
	always @(posedge hclk or negedge hresetn)
		if (!hresetn)
			{rd_q, wr_q} <= 2'b00;
		else
			{rd_q, wr_q} <= {acc && !hwrite && haddr == 32'h80, acc && hwrite && haddr == 32'h84};
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn || !clk_en);
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not zero-wait okay");
	a_upper_zero: assert property (rd_q |-> hrdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	a_read_pending: assert property (rd_q && hrdata[7:0] != 8'h0 |-> $past(irq_pending))
		else $error("flag read without pending interrupt");
	a_flag_sticky: assert property (irq_pending && !(acc && !hwrite && haddr == 32'h80)
		&& !wr_q && !$past(wr_q) |=> irq_pending) else $error("pending dropped without read");
	a_deemph_idle: assert property (!forced_lock |=> deemph_filter_sel == 2'h0)
		else $error("de-emphasis active without forced lock");
	a_release_low: assert property (!irq_oe |-> !irq_out)
		else $error("released pin drives high");
	a_gain_range: assert property ($signed(adc_right_gain) <= 15 && $signed(adc_right_gain) >= -15)
		else $error("gain outside range");
	a_ramp_follow: assert property (ramp_zero_cross_sel == ramp_zero_cross_in)
		else $error("ramp selection not passed on");
	cover property (rd_q && hrdata[7:0] != 8'h0);
	cover property ($fell(irq_pending));
	cover property (!irq_oe && irq_pending);
endmodule // rxic_top_monitor
bind rxic_top rxic_top_monitor mon (.*);
